/* File: core/cdp_pin_mux.sv */
// cdp_pin_mux: cache, tag ram and local dram pin functions.
// assumes all controls come from logic on i_clock; pins are asynchronous.
`timescale 1ns/1ps
module cdp_pin_mux (
  input  wire logic                       i_clock,         // 100 MHz
  input  wire logic                       i_rst,           // sync, high
  input  wire logic                       i_cached_mode,   // 1 = cached
  input  wire logic                       i_wb_cpu,        // wb cpu variant
  input  wire logic                       i_cycle_cacheable, // cur cycle
  input  wire logic                       i_dram_wr_req,   // dram write
  input  wire logic                       i_dram_rd_req,   // dram read
  input  wire logic                       i_refresh_start, // own refresh
  input  wire logic                       i_isa_master,    // isa master on
  input  wire logic                       i_tag_wr_req,    // tag write
  input  wire logic                       i_tag_drive,     // drive tag bus
  input  wire logic [cdp_pkg::TAG_W-1:0]  i_tag_wdata,     // tag to write
  input  wire logic [cdp_pkg::IRQ_W-1:0]  i_irq_edge,      // 1 = edge mode
  input  wire logic [cdp_pkg::IRQ_W-1:0]  i_irq_ack,       // clears edge
  input  wire cdp_pkg::cdp_pin_in_s       i_pins,          // pin levels
  output cdp_pkg::cdp_pin_out_s           o_pins,          // pin drives
  output cdp_pkg::cdp_user_out_s          o_user           // decoded
);
  import cdp_pkg::*;

  // ==========================================================
  // pin synchronisers
  // flops start at idle pin levels: no false channel check or edge
  localparam cdp_pin_in_s PIN_IN_IDLE = '{
    page_cache_disable_in:        1'b0,
    refresh_n:  STROBE_IDLE,
    read_pin:   STROBE_IDLE,
    tag:        '0,
    tag_we_pin: 1'b0
  };

  cdp_pin_in_s sync1;
  cdp_pin_in_s sync2;
  cdp_pin_in_s prev;
  cdp_pin_in_s next_sync1;
  cdp_pin_in_s next_sync2;
  cdp_pin_in_s next_prev;
  logic [1:0]  released;       // refresh pin released, as sync1/sync2 see it
  logic [1:0]  next_released;

  always_comb begin
    next_sync1 = i_pins;
    next_sync2 = sync1;
    next_prev  = sync2;
    next_released = {released[0], ~o_pins.refresh_oe};
  end

  // sync1 feeds sync2 only; edges are taken from sync2 against prev
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync1    <= PIN_IN_IDLE;
      sync2    <= PIN_IN_IDLE;
      prev     <= PIN_IN_IDLE;
      released <= '0;
    end else begin
      sync1    <= next_sync1;
      sync2    <= next_sync2;
      prev     <= next_prev;
      released <= next_released;
    end
  end

  // ==========================================================
  // pin drives
  cdp_pin_out_s next_pins;

  always_comb begin
    next_pins                     = PIN_OUT_RST;
    next_pins.cpu_cache_enable_n  = ~i_cycle_cacheable;
    next_pins.dram_write_enable_n = ~i_dram_wr_req;
    next_pins.refresh_oe          = ~i_isa_master;
    next_pins.refresh_n = i_isa_master ? STROBE_IDLE
                                       : ~i_refresh_start;
    if (i_cached_mode) begin
      next_pins.dram_read_oe       = 1'b1;
      next_pins.dram_read_enable_n = ~i_dram_rd_req;
      next_pins.tag_oe             = i_tag_drive;
      next_pins.tag                = i_tag_wdata;
      next_pins.tag_we_oe          = 1'b1;
      next_pins.tag_write_enable_n = ~i_tag_wr_req;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pins <= PIN_OUT_RST;
    end else begin
      o_pins <= next_pins;
    end
  end

  // ==========================================================
  // interrupt requests, one per shared tag line 7..3
  logic [IRQ_W-1:0] irq;
  logic [IRQ_W-1:0] next_irq;
  logic [IRQ_W-1:0] irq_lvl;
  logic [IRQ_W-1:0] irq_old;

  assign irq_lvl = sync2.tag[TAG_W-1:TAG_IRQ_L];
  assign irq_old = prev.tag[TAG_W-1:TAG_IRQ_L];

  genvar g;
  generate
    for (g = 0; g < IRQ_W; g++) begin : g_irq
      // a new rising edge in the ack cycle still holds the request
      assign next_irq[g] = ~i_cached_mode & (i_irq_edge[g]
        ? ((irq_lvl[g] & ~irq_old[g]) | (irq[g] & ~i_irq_ack[g]))
        : irq_lvl[g]);
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          irq[g] <= 1'b0;
        end else begin
          irq[g] <= next_irq[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // decoded user side
  cdp_user_out_s next_user;

  always_comb begin
    next_user               = USER_OUT_RST;
    next_user.page_attr     = i_wb_cpu ? 1'b0 : sync2.page_cache_disable_in;
    next_user.cacheable_ind = i_wb_cpu & ~sync2.page_cache_disable_in;
    // our own drive lingers two cycles in the synchroniser after release
    next_user.ext_refresh_req = i_isa_master & released[1] & released[0]
                              & prev.refresh_n & ~sync2.refresh_n;
    next_user.irq_req       = next_irq;
    if (i_cached_mode) begin
      next_user.tag_rdata = sync2.tag;
    end else begin
      next_user.channel_check_n = sync2.read_pin;
      next_user.coprocessor_irq = sync2.tag_we_pin;
      next_user.dma_req = sync2.tag[TAG_DRQ_H:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_user <= USER_OUT_RST;
    end else begin
      o_user <= next_user;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  ken_follows_a: assert property (
    i_cycle_cacheable |=> !o_pins.cpu_cache_enable_n)
    else $error("cache enable not asserted on cacheable cycle");
  pcd_reinterp_a: assert property (
    i_wb_cpu && !sync2.page_cache_disable_in |=> o_user.cacheable_ind && !o_user.page_attr)
    else $error("pcd not read as cacheable indication");
  ref_drive_a: assert property (
    !i_isa_master && i_refresh_start |=> o_pins.refresh_oe
      && !o_pins.refresh_n)
    else $error("refresh strobe not driven");
  ref_release_a: assert property (
    i_isa_master |=> !o_pins.refresh_oe ##0 o_pins.refresh_n)
    else $error("refresh strobe not released for isa master");
  mwe_strobe_a: assert property (
    o_pins.dram_write_enable_n != $past(i_dram_wr_req))
    else $error("dram write enable wrong");
  mre_strobe_a: assert property (
    i_cached_mode && i_dram_rd_req |=> o_pins.dram_read_oe
      && !o_pins.dram_read_enable_n)
    else $error("dram read enable wrong");
  iochk_input_a: assert property (
    !i_cached_mode |=> !o_pins.dram_read_oe
      && o_user.channel_check_n == $past(sync2.read_pin))
    else $error("read pin not used as channel check");
  irq_edge_a: assert property (
    !i_cached_mode && i_irq_edge[0] && irq_lvl[0] && !irq_old[0]
      |=> o_user.irq_req[0] ##1 !irq_lvl[0] || o_user.irq_req[0]
        || $past(i_irq_ack[0]))
    else $error("edge request lost");
  irq_no_level_a: assert property (
    !i_cached_mode && i_irq_edge[1] && irq_lvl[1] && irq_old[1]
      && !irq[1] |=> !o_user.irq_req[1])
    else $error("edge mode raised request without edge");
  irq_level_a: assert property (
    !i_cached_mode && !i_irq_edge[2] && irq_lvl[2]
      |=> o_user.irq_req[2] [*1])
    else $error("level request not raised");
  irq_cached_a: assert property (
    i_cached_mode |=> o_user.irq_req == '0)
    else $error("irq raised in cached mode");
  drq_map_a: assert property (
    !i_cached_mode |=> o_user.dma_req == $past(sync2.tag[TAG_DRQ_H:0]))
    else $error("dma request mapping wrong");
  tag_write_enable_n_strobe_a: assert property (
    i_cached_mode && i_tag_wr_req |=> o_pins.tag_we_oe
      && !o_pins.tag_write_enable_n)
    else $error("tag write strobe not asserted");
  coprocessor_irq_input_a: assert property (
    !i_cached_mode |=> !o_pins.tag_we_oe
      && o_user.coprocessor_irq == $past(sync2.tag_we_pin))
    else $error("coprocessor irq not taken from tag write pin");
  tag_oe_mode_a: assert property (
    !i_cached_mode |=> !o_pins.tag_oe)
    else $error("tag lines driven in non-cached mode");

  ext_refresh_c: cover property (
    i_isa_master [*3] ##1 o_user.ext_refresh_req);
  edge_ack_c: cover property (
    o_user.irq_req[0] && i_irq_ack[0] ##1 !o_user.irq_req[0]);
  tag_write_c: cover property (
    i_cached_mode && i_tag_wr_req && i_tag_drive);
  mode_switch_c: cover property (
    i_cached_mode ##1 !i_cached_mode);
endmodule

/* File: shared/cdp_pkg.sv */
// cdp_pkg: constants and pin carriers for the cache/dram pin mux.
// assumes one system clock; pins are sampled by the core itself.
package cdp_pkg;
  // ==========================================================
  // widths and field positions
  localparam int unsigned TAG_W     = 8;
  localparam int unsigned IRQ_W     = 5;
  localparam int unsigned DRQ_W     = 3;
  localparam int unsigned TAG_IRQ_L = 3;  // tag bits 7..3 -> irq 15,14,12,7,3
  localparam int unsigned TAG_DRQ_H = 2;  // tag bits 2..0 -> drq 7..5

  // ==========================================================
  // reset values
  localparam logic STROBE_IDLE = 1'b1;  // active-low strobes deasserted
  localparam logic OE_OFF      = 1'b0;

  // ==========================================================
  // pin carriers
  typedef struct packed {
    logic             page_cache_disable_in;         // page_cache_disable_in
    logic             refresh_n;   // refresh strobe level
    logic             read_pin;    // dram read pin level (channel check)
    logic [TAG_W-1:0] tag;         // tag_data_lines level
    logic             tag_we_pin;  // tag write pin level (coprocessor_irq)
  } cdp_pin_in_s;

  typedef struct packed {
    logic             cpu_cache_enable_n;
    logic             dram_write_enable_n;
    logic             dram_read_enable_n;
    logic             dram_read_oe;
    logic             refresh_n;
    logic             refresh_oe;
    logic [TAG_W-1:0] tag;
    logic             tag_oe;
    logic             tag_write_enable_n;
    logic             tag_we_oe;
  } cdp_pin_out_s;

  localparam cdp_pin_out_s PIN_OUT_RST = '{
    cpu_cache_enable_n:  STROBE_IDLE,
    dram_write_enable_n: STROBE_IDLE,
    dram_read_enable_n:  STROBE_IDLE,
    dram_read_oe:        OE_OFF,
    refresh_n:           STROBE_IDLE,
    refresh_oe:          OE_OFF,
    tag:                 '0,
    tag_oe:              OE_OFF,
    tag_write_enable_n:  STROBE_IDLE,
    tag_we_oe:           OE_OFF
  };

  typedef struct packed {
    logic             page_attr;       // pcd level, plain processor
    logic             cacheable_ind;   // pcd read active-low, wb processor
    logic             channel_check_n; // iochk level, non-cached
    logic             coprocessor_irq;
    logic             ext_refresh_req; // one-cycle pulse
    logic [IRQ_W-1:0] irq_req;
    logic [DRQ_W-1:0] dma_req;
    logic [TAG_W-1:0] tag_rdata;
  } cdp_user_out_s;

  localparam cdp_user_out_s USER_OUT_RST = '{
    page_attr:       1'b0,
    cacheable_ind:   1'b0,
    channel_check_n: STROBE_IDLE,
    coprocessor_irq: 1'b0,
    ext_refresh_req: 1'b0,
    irq_req:         '0,
    dma_req:         '0,
    tag_rdata:       '0
  };
endpackage

/* File: tb/cdp_far_model.sv */
// far side of the pin mux: cpu pcd, refresh master, tag ram, sources.
// assumes the bench sets in i_src what the far parties drive.
`timescale 1ns/1ps
module cdp_far_model (
  input  wire cdp_pkg::cdp_pin_out_s i_dev,  // device drives
  input  wire cdp_pkg::cdp_pin_in_s  i_src,  // far-side levels
  output cdp_pkg::cdp_pin_in_s       o_pins  // resolved wires
);
  import cdp_pkg::*;
  // ==========================================================
  // wire resolution
  // irq source levels come from i_src; the bench holds them until acked
  always_comb begin
    o_pins = i_src;
    if (i_dev.refresh_oe) o_pins.refresh_n = i_dev.refresh_n;
    if (i_dev.dram_read_oe) o_pins.read_pin = i_dev.dram_read_enable_n;
    if (i_dev.tag_oe) o_pins.tag = i_dev.tag;
    if (i_dev.tag_we_oe) o_pins.tag_we_pin = i_dev.tag_write_enable_n;
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the cache/dram pin mux.
// assumes the far model resolves every shared pin.
`timescale 1ns/1ps
module testbench;
  import cdp_pkg::*;
  // ==========================================================
  // signals
  logic          i_clock = 0;
  logic          i_rst   = 1;
  logic [8:0]    ctl     = '0;  // mode,wb,cache,wr,rd,ref,isa,twr,tdrv
  logic [7:0]    wd      = '0;
  logic [4:0]    edg     = '0;
  logic [4:0]    ack     = '0;
  cdp_pin_in_s   src     = 12'h400;
  cdp_pin_in_s   pins;
  cdp_pin_out_s  o_pins;
  cdp_user_out_s o_user, e;
  logic [31:0]   seed = 32'h114;
  logic [31:0]   r;
  logic [3:0]    n;
  int            bad_count, check_count, cyc;

  always #5 i_clock = ~i_clock;

  cdp_pin_mux cdp_pin_mux_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_cached_mode(ctl[0]), .i_wb_cpu(ctl[1]), .i_cycle_cacheable(ctl[2]),
    .i_dram_wr_req(ctl[3]), .i_dram_rd_req(ctl[4]),
    .i_refresh_start(ctl[5]), .i_isa_master(ctl[6]),
    .i_tag_wr_req(ctl[7]), .i_tag_drive(ctl[8]), .i_tag_wdata(wd),
    .i_irq_edge(edg), .i_irq_ack(ack), .i_pins(pins), .o_pins(o_pins),
    .o_user(o_user));
  cdp_far_model cdp_far_model_inst (.i_dev(o_pins), .i_src(src),
    .o_pins(pins));

  // ==========================================================
  // helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic cdp_pin_out_s exp_pins(logic [8:0] c, logic [7:0] d);
    cdp_pin_out_s x;
    x.cpu_cache_enable_n  = !c[2];
    x.dram_write_enable_n = !c[3];
    x.dram_read_enable_n  = !(c[0] & c[4]);
    x.dram_read_oe        = c[0];
    x.refresh_n           = !(c[5] & !c[6]);
    x.refresh_oe          = !c[6];
    x.tag                 = c[0] ? d : 8'h00;
    x.tag_oe              = c[0] & c[8];
    x.tag_write_enable_n  = !(c[0] & c[7]);
    x.tag_we_oe           = c[0];
    return x;
  endfunction

  task check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task summarize;
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard: whole run is about 1400 cycles
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    cdp_pin_out_s g;
    repeat (6) @(posedge i_clock);
    i_rst <= 0;
    #1 check(64'(o_pins), 64'(PIN_OUT_RST));
    check(64'(o_user), 64'(USER_OUT_RST));
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      @(posedge i_clock);
      ctl <= r[8:0];
      wd  <= r[31:24];
      @(posedge i_clock);
      #1 g = exp_pins(r[8:0], r[31:24]);
      check(64'(o_pins), 64'(g));
    end
    // level irqs, dma, channel check, coprocessor irq, pcd
    for (int i = 0; i < 150; i++) begin
      r = rnd();
      @(posedge i_clock);
      ctl <= {7'h00, r[1:0]};
      src <= {r[27], 1'b1, r[25:16]};
      // one extra edge: a pin the design released last cycle must flush
      repeat (4) @(posedge i_clock);
      #1 e = USER_OUT_RST;
      if (r[1]) begin
        e.page_attr     = 1'b0;
        e.cacheable_ind = !r[27];
      end else e.page_attr = r[27];
      e.irq_req         = r[0] ? 5'h00 : r[24:20];
      e.dma_req         = r[0] ? 3'h0 : r[19:17];
      e.channel_check_n = r[0] ? 1'b1 : r[25];
      e.coprocessor_irq = r[0] ? 1'b0 : r[16];
      e.tag_rdata       = r[0] ? r[24:17] : 8'h00;
      check(64'(o_user), 64'(e));
    end
    // edge irqs: rise sets, ack clears while input still high
    @(posedge i_clock);
    ctl <= '0;
    edg <= 5'h1f;
    src <= 12'h400;
    ack <= 5'h1f;
    repeat (4) @(posedge i_clock);
    ack <= 5'h00;
    src.tag <= 8'hf8;
    repeat (3) @(posedge i_clock);
    #1 check(64'(o_user.irq_req), 64'h1f);
    @(posedge i_clock);
    ack <= 5'h1f;
    @(posedge i_clock);
    ack <= 5'h00;
    repeat (2) @(posedge i_clock);
    #1 check(64'(o_user.irq_req), 64'h00);
    // isa master requests refresh: one pulse per falling strobe
    @(posedge i_clock);
    ctl <= 9'h040;
    repeat (4) @(posedge i_clock);
    src.refresh_n <= 1'b0;
    n = 4'h0;
    repeat (8) begin
      @(posedge i_clock);
      #1 n = n + {3'h0, o_user.ext_refresh_req};
    end
    check(64'(n), 64'h1);
    check(64'(o_pins.refresh_oe), 64'h0);
    summarize();
  end
endmodule
